/* File: logic/cdc_console_display.sv */
// Console display controller: host byte bus, panel switches and lamps, APB registers
`timescale 1ns/100ps
`include "cdc_defs.svh"

// Summary of operation
// - Match device address one on all eight lines
// - Address command pulse captures match into enable
// - Status, write, read and control strobes act only while display enable set
// - Addressing asserts sync, clears output byte counter
// - Counter zero write loads register one high
// - Write strobe fall advances byte counter
// - Second write loads register one low byte
// - Successive write bytes steered by counter value
// - Counts two, three load register two bytes
// - Latched bytes hold and drive lamps continuously
// - System clear resets read byte select
// - First read drives switch bits eight to fifteen
// - Read strobe fall toggles byte select
// - Next read drives switch bits zero to seven
// - Status: mode high nibble, select low nibble
// - Status byte driven only during status enable
// - Mode codes per switch position table
// - Register select codes, pairs as one plus index
// - Execute press loads 1 us pulse counter, sets attention flip-flop
// - Address sync clears attention flip-flop
// - Execute in variable mode sets step level
// - Step level enables adjustable repeat oscillator
// - Each oscillator cycle fires 5 ms pulse
// - Oscillator repeats attention after execute pressed
// - Output control sets programmable mode, no counter reset
module cdc_console_display
	import cdc_pkg::*;
#(
	parameter int EXEC_PULSE_CYC = `CDC_EXEC_CYC,
	parameter int STEP_PULSE_CYC = `CDC_STEP_CYC,
	parameter int MS_TICK_CYC    = `CDC_MS_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  out_data_lines,
	input  wire logic        address_command,
	input  wire logic        status_read_strobe,
	input  wire logic        byte_write_strobe,
	input  wire logic        byte_read_strobe,
	input  wire logic        output_control_strobe,
	input  wire logic        system_clear,
	input  wire logic        execute_switch,
	input  wire logic [7:0]  mode_switch,
	input  wire logic [11:0] register_switch,
	input  wire logic [15:0] data_switches,
	output logic      [7:0]  in_data_lines,
	output logic             in_data_oe,
	output logic      [15:0] indicator_one,
	output logic      [15:0] indicator_two,
	output logic             console_attention,
	output logic             single_step_level
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	generate
		if (EXEC_PULSE_CYC < 1 || EXEC_PULSE_CYC > 65535 || STEP_PULSE_CYC < 1 ||
		    STEP_PULSE_CYC > 16777215 || MS_TICK_CYC < 1 || MS_TICK_CYC > 65535 ||
		    STEP_PULSE_CYC >= 10 * MS_TICK_CYC) begin : g_bad
			$error("cdc_console_display: timing parameter out of range");
		end
	endgenerate

	localparam int SW = 51;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Mode switch position (VARIABLE_STEP_MODE,HALT,RUN,ADDRESS_COMMAND,MEMORY_READ_MODE,MEMORY_WRITE_MODE,HALT_FLOAT_MODE,VARIABLE_FLOAT_MODE) to code
	function automatic logic [3:0] mode_code(input logic [7:0] p);
		logic [3:0] c;
		c = 4'h0;
		if (p[0]) c = `CDC_MODE_VARIABLE_STEP_MODE;
		else if (p[1]) c = `CDC_MODE_HALT;
		else if (p[2]) c = `CDC_MODE_RUN;
		else if (p[3]) c = `CDC_MODE_ADDRESS_COMMAND;
		else if (p[4]) c = `CDC_MODE_MEMORY_READ_MODE;
		else if (p[5]) c = `CDC_MODE_MEMORY_WRITE_MODE;
		else if (p[6]) c = `CDC_MODE_HALT_FLOAT_MODE;
		else if (p[7]) c = `CDC_MODE_VARIABLE_FLOAT_MODE;
		return c;
	endfunction

	// Register switch position (OFF,REG,INSTRUCTION_VIEW,STATUS_WORD_VIEW,pair 0..7) to code
	function automatic logic [3:0] rsel_code(input logic [11:0] p);
		logic [3:0] c;
		c = `CDC_RSEL_OFF;
		if (p[1]) c = `CDC_RSEL_REG;
		else if (p[2]) c = `CDC_RSEL_INSTRUCTION_VIEW;
		else if (p[3]) c = `CDC_RSEL_PSW;
		for (int i = 0; i < 8; i++) begin
			if (p[4 + i]) c = {`CDC_RSEL_PAIR, 3'(i)};
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [SW-1:0] sy1_q, sy2_q, sy3_q;
	logic [SW-1:0] raw;
	assign raw = {out_data_lines, data_switches, register_switch, mode_switch, execute_switch,
	              system_clear, output_control_strobe, byte_read_strobe, byte_write_strobe,
	              status_read_strobe, address_command};

	// Two stages plus an edge-history stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q <= '0;
			sy2_q <= '0;
			sy3_q <= '0;
		end else begin
			sy1_q <= raw;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	logic       adr_lvl, adr_rise, sr_lvl, wr_rise, wr_fall, rd_lvl, rd_fall, oc_rise;
	logic       clr_lvl, exe_rise;
	logic [7:0] mode_s, odata;
	logic [11:0] rsw_s;
	logic [15:0] dsw_s;
	assign adr_lvl  = sy2_q[0];
	assign adr_rise = sy2_q[0] & ~sy3_q[0];
	assign sr_lvl   = sy2_q[1];
	assign wr_rise  = sy2_q[2] & ~sy3_q[2];
	assign wr_fall  = ~sy2_q[2] & sy3_q[2];
	assign rd_lvl   = sy2_q[3];
	assign rd_fall  = ~sy2_q[3] & sy3_q[3];
	assign oc_rise  = sy2_q[4] & ~sy3_q[4];
	assign clr_lvl  = sy2_q[5];
	assign exe_rise = sy2_q[6] & ~sy3_q[6];
	assign mode_s   = sy2_q[14:7];
	assign rsw_s    = sy2_q[26:15];
	assign dsw_s    = sy2_q[42:27];
	assign odata    = sy2_q[50:43];

	// ----------------------------------------------------------------
	// Addressing
	// ----------------------------------------------------------------
	logic addr_en_q, prog_q, addr_match, address_sync;
	assign addr_match   = (odata == `CDC_DEV_ADDR);
	assign address_sync = adr_lvl & addr_match;

	// Display enable follows the match on each address command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_en_q <= 1'b0;
		end else if (clr_lvl) begin
			addr_en_q <= 1'b0;
		end else if (adr_rise) begin
			addr_en_q <= addr_match;
		end
	end

	// Gated strobes
	logic status_enable, wr_rise_g, wr_fall_g, gated_byte_read, rd_fall_g, oc_g;
	assign status_enable   = sr_lvl & addr_en_q;
	assign wr_rise_g       = wr_rise & addr_en_q;
	assign wr_fall_g       = wr_fall & addr_en_q;
	assign gated_byte_read = rd_lvl & addr_en_q;
	assign rd_fall_g       = rd_fall & addr_en_q;
	assign oc_g            = oc_rise & addr_en_q;

	// Programmable mode latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_q <= 1'b0;
		end else if (clr_lvl) begin
			prog_q <= 1'b0;
		end else if (oc_g) begin
			prog_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Output bytes to the indicator registers
	// ----------------------------------------------------------------
	logic [1:0] byte_cnt_q;
	logic       counter_increment;
	assign counter_increment = wr_fall_g;

	// Byte counter: clear, sync reset unless programmable, advance on fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_cnt_q <= `CDC_CNT_RESET;
		end else if (clr_lvl || (address_sync && !prog_q)) begin
			byte_cnt_q <= `CDC_CNT_RESET;
		end else if (counter_increment) begin
			byte_cnt_q <= byte_cnt_q + 2'h1;
		end
	end

	logic [15:0] ind_one_q, ind_two_q;
	// Storage latches steered by counter, held until rewritten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_one_q <= 16'h0000;
			ind_two_q <= 16'h0000;
		end else if (wr_rise_g) begin
			case (byte_cnt_q)
				2'h0: ind_one_q[15:8] <= odata;
				2'h1: ind_one_q[7:0]  <= odata;
				2'h2: ind_two_q[15:8] <= odata;
				2'h3: ind_two_q[7:0]  <= odata;
				default: ind_one_q <= ind_one_q;
			endcase
		end
	end
	assign indicator_one = ind_one_q;
	assign indicator_two = ind_two_q;

	// ----------------------------------------------------------------
	// Switch and status input
	// ----------------------------------------------------------------
	logic       rd_sel_q;
	logic       low_switch_byte_enable, high_switch_byte_enable;
	logic [7:0] status_byte;
	assign low_switch_byte_enable  = gated_byte_read & ~rd_sel_q;
	assign high_switch_byte_enable = gated_byte_read & rd_sel_q;
	assign status_byte = {mode_code(mode_s), rsel_code(rsw_s)};

	// Read byte select: clear, sync reset unless programmable, toggle on fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_sel_q <= 1'b0;
		end else if (clr_lvl || (address_sync && !prog_q)) begin
			rd_sel_q <= 1'b0;
		end else if (rd_fall_g) begin
			rd_sel_q <= ~rd_sel_q;
		end
	end

	logic [7:0] in_data_q;
	logic       in_oe_q;
	// Input data line driver; status has priority over switch bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_data_q <= 8'h00;
			in_oe_q   <= 1'b0;
		end else begin
			in_oe_q <= status_enable | gated_byte_read;
			if (status_enable) begin
				in_data_q <= status_byte;
			end else if (low_switch_byte_enable) begin
				in_data_q <= dsw_s[15:8];
			end else if (high_switch_byte_enable) begin
				in_data_q <= dsw_s[7:0];
			end else begin
				in_data_q <= 8'h00;
			end
		end
	end
	assign in_data_lines = in_data_q;
	assign in_data_oe    = in_oe_q;

	// ----------------------------------------------------------------
	// Execute pulse, attention and step level
	// ----------------------------------------------------------------
	logic        osc_fire, exec_fire, attn_q, step_q, step_out_q;
	logic [15:0] exec_cnt_q;
	assign exec_fire = exe_rise | osc_fire;

	// One microsecond execute pulse counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_cnt_q <= 16'h0000;
		end else if (exec_fire) begin
			exec_cnt_q <= 16'(EXEC_PULSE_CYC);
		end else if (exec_cnt_q != 16'h0000) begin
			exec_cnt_q <= exec_cnt_q - 16'h0001;
		end
	end

	// Attention: pulse sets, address sync clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			attn_q <= 1'b0;
		end else if (exec_fire) begin
			attn_q <= 1'b1;
		end else if (address_sync || clr_lvl) begin
			attn_q <= 1'b0;
		end
	end
	assign console_attention = attn_q;

	// Step latch captures variable mode on the execute pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_q     <= 1'b0;
			step_out_q <= 1'b0;
		end else begin
			if (clr_lvl) begin
				step_q <= 1'b0;
			end else if (exec_fire) begin
				step_q <= mode_s[0];
			end
			step_out_q <= step_q;
		end
	end
	assign single_step_level = step_out_q;

	// ----------------------------------------------------------------
	// Repeat oscillator
	// ----------------------------------------------------------------
	logic [31:0]    ctrl_q;
	logic [9:0]     period_ms;
	logic [15:0]    ms_cnt_q;
	logic [9:0]     per_cnt_q;
	logic [23:0]    pulse_cnt_q;
	cdc_osc_state_t osc_q;
	logic           ms_tick;
	assign period_ms = ctrl_q[`CDC_CTRL_PER_MSB:0];
	assign ms_tick   = (ms_cnt_q == 16'(MS_TICK_CYC - 1));
	// Reached or passed, so a period shorter than the pulse still repeats
	assign osc_fire  = (osc_q == CDC_OSC_COUNT) && ms_tick &&
	                   (per_cnt_q >= period_ms - 10'h001);

	// Millisecond prescaler, runs only while oscillating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_q <= 16'h0000;
		end else if (osc_q == CDC_OSC_IDLE || ms_tick) begin
			ms_cnt_q <= 16'h0000;
		end else begin
			ms_cnt_q <= ms_cnt_q + 16'h0001;
		end
	end

	// Period count in milliseconds; pulse length tracked alongside
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q       <= CDC_OSC_IDLE;
			per_cnt_q   <= 10'h000;
			pulse_cnt_q <= 24'h00_0000;
		end else begin
			case (osc_q)
				CDC_OSC_IDLE: begin
					per_cnt_q <= 10'h000;
					if (step_q && period_ms != 10'h000) begin
						osc_q <= CDC_OSC_COUNT;
					end
				end
				CDC_OSC_COUNT: begin
					if (!step_q || period_ms == 10'h000) begin
						osc_q <= CDC_OSC_IDLE;
					end else if (osc_fire) begin
						per_cnt_q   <= 10'h000;
						pulse_cnt_q <= 24'(STEP_PULSE_CYC - 1);
						osc_q       <= CDC_OSC_PULSE;
					end else if (ms_tick) begin
						per_cnt_q <= per_cnt_q + 10'h001;
					end
				end
				CDC_OSC_PULSE: begin
					if (ms_tick) begin
						per_cnt_q <= per_cnt_q + 10'h001;
					end
					if (pulse_cnt_q == 24'h00_0000) begin
						osc_q <= CDC_OSC_COUNT;
					end else begin
						pulse_cnt_q <= pulse_cnt_q - 24'h00_0001;
					end
				end
				default: osc_q <= CDC_OSC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q, acc, hit;
	assign acc = psel & penable & pready_q;
	assign hit = (paddr == `CDC_OFS_CTRL) || (paddr == `CDC_OFS_STATE) ||
	             (paddr == `CDC_OFS_IND);

	// One wait state, read data and error set with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~hit;
			prdata_q  <= 32'h0000_0000;
			if (psel && penable && !pready_q && !pwrite) begin
				case (paddr)
					`CDC_OFS_CTRL:  prdata_q <= ctrl_q;
					`CDC_OFS_STATE: prdata_q <= {16'h0000, status_byte, 1'b0, rd_sel_q,
					                             byte_cnt_q, step_q, attn_q, prog_q,
					                             addr_en_q};
					`CDC_OFS_IND:   prdata_q <= {ind_two_q, ind_one_q};
					default:        prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register: oscillator period in milliseconds, zero stops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CDC_CTRL_RESET;
		end else if (acc && pwrite && paddr == `CDC_OFS_CTRL) begin
			ctrl_q <= {22'h00_0000, pwdata[`CDC_CTRL_PER_MSB:0]};
		end
	end
	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_fire;
		exec_fire ##1 attn_q;
	endsequence
	sequence s_hold_pulse;
		exec_cnt_q == 16'(EXEC_PULSE_CYC);
	endsequence

	chk_addr_capture: assert property (adr_rise && !clr_lvl |=> addr_en_q == $past(addr_match))
		else $error("enable not taken from address match");
	chk_gate_write: assert property (wr_rise && !addr_en_q |=> $stable(ind_one_q) && $stable(ind_two_q))
		else $error("indicator written while not addressed");
	chk_sync_count: assert property (address_sync && !prog_q |=> byte_cnt_q == 2'h0)
		else $error("address sync did not clear byte counter");
	chk_lane_zero: assert property (wr_rise_g && byte_cnt_q == 2'h0 |=> ind_one_q[15:8] == $past(odata))
		else $error("first byte not in register one high");
	chk_count_step: assert property (wr_fall_g && !clr_lvl && !address_sync |=> byte_cnt_q == $past(byte_cnt_q) + 2'h1)
		else $error("byte counter did not advance");
	chk_read_toggle: assert property (rd_fall_g && !clr_lvl && !address_sync |=> rd_sel_q != $past(rd_sel_q))
		else $error("read select did not toggle");
	chk_status_drive: assert property (status_enable |=> in_oe_q && in_data_q == $past(status_byte))
		else $error("status byte not driven");
	chk_attn_pulse: assert property (exec_fire |-> s_fire ##0 s_hold_pulse)
		else $error("execute pulse or attention missing");
	chk_step_level: assert property (exec_fire && !clr_lvl |=> ##1 single_step_level == $past(mode_s[0], 2))
		else $error("step level not from variable mode");
	chk_prog_hold: assert property (prog_q && address_sync && !clr_lvl && !wr_fall_g |=> $stable(byte_cnt_q))
		else $error("programmable mode lost counter");

endmodule

/* File: logic/cdc_defs.svh */
// Constants for the console display controller: offsets, fields, resets and timings
`ifndef CDC_DEFS_SVH
`define CDC_DEFS_SVH

// ----------------------------------------------------------------
// Host bus addressing
// ----------------------------------------------------------------
`define CDC_DEV_ADDR        8'h01
`define CDC_CNT_RESET       2'h0

// ----------------------------------------------------------------
// Register offsets on the APB side
// ----------------------------------------------------------------
`define CDC_OFS_CTRL        12'h000
`define CDC_OFS_STATE       12'h004
`define CDC_OFS_IND         12'h008
`define CDC_CTRL_RESET      32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CDC_CTRL_PER_MSB    9
`define CDC_ST_EN           0
`define CDC_ST_PROG         1
`define CDC_ST_ATTN         2
`define CDC_ST_STEP         3
`define CDC_ST_CNT_LSB      4
`define CDC_ST_SEL          6
`define CDC_ST_BYTE_LSB     8

// ----------------------------------------------------------------
// Mode and register-select codes
// ----------------------------------------------------------------
`define CDC_MODE_VARIABLE_STEP_MODE       4'h4
`define CDC_MODE_HALT       4'hc
`define CDC_MODE_RUN        4'h8
`define CDC_MODE_ADDRESS_COMMAND       4'h3
`define CDC_MODE_MEMORY_READ_MODE       4'h2
`define CDC_MODE_MEMORY_WRITE_MODE       4'h1
`define CDC_MODE_HALT_FLOAT_MODE       4'he
`define CDC_MODE_VARIABLE_FLOAT_MODE       4'h6
`define CDC_RSEL_OFF        4'h0
`define CDC_RSEL_REG        4'h1
`define CDC_RSEL_INSTRUCTION_VIEW       4'h2
`define CDC_RSEL_PSW        4'h4
`define CDC_RSEL_PAIR       1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CDC_CLK_NS          25
`define CDC_EXEC_NS         1000
`define CDC_STEP_MS         5
`define CDC_MS_NS           1000000
`define CDC_EXEC_CYC        ((`CDC_EXEC_NS + `CDC_CLK_NS - 1) / `CDC_CLK_NS)
`define CDC_MS_CYC          (`CDC_MS_NS / `CDC_CLK_NS)
`define CDC_STEP_CYC        (`CDC_STEP_MS * `CDC_MS_CYC)

`endif

/* File: logic/cdc_pkg.sv */
// Types shared by the console display controller
package cdc_pkg;

	// Repeat oscillator states
	typedef enum logic [2:0] {
		CDC_OSC_IDLE  = 3'b001,
		CDC_OSC_COUNT = 3'b010,
		CDC_OSC_PULSE = 3'b100
	} cdc_osc_state_t;

endpackage

/* File: verif/cdc_host_model.sv */
// Host processor model driving the console byte bus strobes
`timescale 1ns/100ps
module cdc_host_model (
	input  wire logic       pclk,
	output logic      [7:0] out_data_lines,
	output logic            address_command,
	output logic            status_read_strobe,
	output logic            byte_write_strobe,
	output logic            byte_read_strobe,
	output logic            output_control_strobe,
	output logic            system_clear,
	input  wire logic [7:0] in_data_lines,
	input  wire logic       in_data_oe
);
	logic [5:0] stb = 6'h00;
	logic [8:0] got;

	// Strobe index: 0 addr, 1 status, 2 write, 3 read, 4 control, 5 clear
	assign {system_clear, output_control_strobe, byte_read_strobe, byte_write_strobe,
		status_read_strobe, address_command} = stb;
	initial out_data_lines = 8'h00;

	// One strobe: data settles first, level held five cycles each way
	task op(input int k, input logic [7:0] d);
		out_data_lines <= d;
		@(posedge pclk);
		stb[k] <= 1'b1;
		repeat (5) @(posedge pclk);
		got = {in_data_oe, in_data_lines};
		stb[k] <= 1'b0;
		repeat (5) @(posedge pclk);
		out_data_lines <= ~d; // Released lines show no stale value
		@(posedge pclk);
	endtask
endmodule

/* File: verif/console_display_controller_bench.sv */
// Self-checking bench for the console display controller
`timescale 1ns/100ps
`include "cdc_defs.svh"
module console_display_controller_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, register_switch = 12'h001;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, err, execute_switch = 1'b0;
	logic [7:0] mode_switch = 8'h01, out_data_lines, in_data_lines;
	logic [15:0] data_switches = 16'h0000, indicator_one, indicator_two;
	logic address_command, status_read_strobe, byte_write_strobe, byte_read_strobe;
	logic output_control_strobe, system_clear, in_data_oe, console_attention;
	logic single_step_level;
	logic [3:0] md[8] = '{`CDC_MODE_VARIABLE_STEP_MODE, `CDC_MODE_HALT, `CDC_MODE_RUN, `CDC_MODE_ADDRESS_COMMAND,
		`CDC_MODE_MEMORY_READ_MODE, `CDC_MODE_MEMORY_WRITE_MODE, `CDC_MODE_HALT_FLOAT_MODE, `CDC_MODE_VARIABLE_FLOAT_MODE};
	logic [3:0] rs[4] = '{`CDC_RSEL_OFF, `CDC_RSEL_REG, `CDC_RSEL_INSTRUCTION_VIEW, `CDC_RSEL_PSW};
	int failures = 0, cmp_count = 0, cyc = 0;

	// Clock, shortened timings
	always #12.5 pclk = ~pclk;
	cdc_console_display #(.EXEC_PULSE_CYC(4), .STEP_PULSE_CYC(20), .MS_TICK_CYC(4)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .out_data_lines, .address_command, .status_read_strobe,
		.byte_write_strobe, .byte_read_strobe, .output_control_strobe, .system_clear,
		.execute_switch, .mode_switch, .register_switch, .data_switches, .in_data_lines,
		.in_data_oe, .indicator_one, .indicator_two, .console_attention,
		.single_step_level);
	cdc_host_model host (.pclk, .out_data_lines, .address_command, .status_read_strobe,
		.byte_write_strobe, .byte_read_strobe, .output_control_strobe, .system_clear,
		.in_data_lines, .in_data_oe);

	// Comparison and report
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask

	// Verdict and end of run
	task summarize;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			summarize;
		end
	end

	// APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Bounded wait for the attention request
	task wait_attn(input int lim);
		for (int n = 0; n < lim && console_attention !== 1'b1; n++) @(posedge pclk);
	endtask

	// Four writes fill both lamp registers; refused writes change nothing
	task t_write;
		logic [7:0] b[4] = '{8'h12, 8'h34, 8'h56, 8'h78};
		host.op(0, 8'h01);
		foreach (b[i]) host.op(2, b[i]);
		chk("ind1", indicator_one, 16'h1234);
		chk("ind2", indicator_two, 16'h5678);
		host.op(0, 8'h01);
		host.op(2, 8'hab);
		host.op(0, 8'h02);
		host.op(2, 8'hff);
		chk("ind1 off", indicator_one, 16'hab34);
		host.op(0, 8'h01);
		host.op(2, 8'h9a);
		chk("ind1 readdr", indicator_one, 16'h9a34);
	endtask

	// Switch reads, programmable mode and system clear
	task t_read;
		data_switches <= 16'ha55a;
		host.op(0, 8'h01);
		host.op(4, 8'h00);
		host.op(3, 8'h00);
		chk("rd hi", host.got, 9'h1a5);
		chk("oe idle", in_data_oe, 1'b0);
		host.op(0, 8'h01);
		host.op(3, 8'h00);
		chk("rd lo", host.got, 9'h15a);
		host.op(3, 8'h00);
		chk("rd hi2", host.got, 9'h1a5);
		host.op(5, 8'h00);
		apb(1'b0, `CDC_OFS_STATE, 32'h0000_0000);
		chk("state clr", rd[6:0], 7'h00);
		host.op(0, 8'h01);
		host.op(3, 8'h00);
		chk("rd clr", host.got, 9'h1a5);
	endtask

	// Every mode and register-select position through the status byte
	task t_status;
		for (int i = 0; i < 12; i++) begin
			mode_switch <= 8'h01 << (i % 8);
			register_switch <= 12'h001 << i;
			host.op(1, 8'h00);
			chk("status", host.got, {1'b1, md[i%8], i < 4 ? rs[i] : 4'(i + 4)});
		end
	endtask

	// Execute, attention clear, variable step repeat
	task t_exec;
		mode_switch <= 8'h01;
		@(posedge pclk);
		execute_switch <= 1'b1;
		wait_attn(30);
		chk("attn", console_attention, 1'b1);
		repeat (8) @(posedge pclk);
		chk("step", single_step_level, 1'b1);
		execute_switch <= 1'b0;
		host.op(0, 8'h01);
		chk("attn clr", console_attention, 1'b0);
		apb(1'b1, `CDC_OFS_CTRL, 32'h0000_000a);
		apb(1'b0, `CDC_OFS_CTRL, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_000a);
		wait_attn(300);
		chk("repeat", console_attention, 1'b1);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("unmapped", err, 1'b1);
		apb(1'b1, `CDC_OFS_CTRL, 32'h0000_0000);
		host.op(5, 8'h00);
		chk("step clr", single_step_level, 1'b0);
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset", {indicator_one, indicator_two}, 32'h0000_0000);
		t_write;
		t_read;
		t_status;
		t_exec;
		summarize;
	end
endmodule
